// File: scc_pkg.sv
// Package: constants and carrier types for sync, clamp and coast control
package scc_pkg;
    // Register addresses and field positions, kept for software reference
    localparam logic [7:0] SCC_REG_LINE_POL = 8'h12;
    localparam logic [7:0] SCC_REG_FRAME_POL = 8'h14;
    localparam logic [7:0] SCC_REG_CLK_SRC = 8'h03;
    localparam logic [7:0] SCC_REG_CLAMP_COAST = 8'h18;
    localparam logic [7:0] SCC_REG_CLAMP_POL = 8'h1b;
    localparam logic [7:0] SCC_REG_SLICER_SEL = 8'h1d;
    localparam logic [7:0] SCC_REG_PWR = 8'h1e;
    localparam int SCC_POL_HI = 5;
    localparam int SCC_POL_LO = 4;
    localparam int SCC_CLAMP_SRC_BIT = 4;
    localparam int SCC_EXT_CLK_BIT = 2;
    localparam int SCC_PD_SEL_BIT = 4;
    localparam int SCC_PD_POL_BIT = 2;
    // Reset values
    localparam logic [1:0] SCC_COAST_POL_RST = 2'h1;
    localparam logic SCC_CLAMP_SRC_RST = 1'h0;
    // Slicer threshold in mV: step, range and default
    localparam int SCC_SLICE_STEP_MV = 8;
    localparam int SCC_SLICE_MAX_MV = 256;
    localparam int SCC_SLICE_DEF_MV = 128;
    localparam logic [4:0] SCC_SLICE_DEF_CODE = 5'(SCC_SLICE_DEF_MV / SCC_SLICE_STEP_MV - 1);
    // Polarity field: bit 1 selects manual, bit 0 gives the manual level
    localparam int SCC_PF_MANUAL = 1;
    localparam int SCC_PF_LEVEL = 0;
    // Auto detect: level seen longer than half a window is inactive
    localparam int SCC_AUTO_WIN = 256;
    // Slicer output source
    typedef enum logic [1:0] {
        SCC_SRC_SOG = 2'h0,
        SCC_SRC_LINE = 2'h1,
        SCC_SRC_REGEN = 2'h2,
        SCC_SRC_FILT = 2'h3
    } scc_src_e;
    typedef struct packed {
        logic [1:0] line_pol;
        logic [1:0] frame_pol;
        logic [1:0] clamp_pol;
        logic [1:0] coast_pol;
        logic clamp_ext;
        logic ext_clk;
        logic pd_sel;
        logic pd_pol;
        logic [1:0] slicer_sel;
        logic [4:0] slice_code;
        logic [7:0] clamp_delay;
        logic [7:0] clamp_width;
        logic [7:0] regen_width;
        logic regen_pol;
    } scc_cfg_s;
endpackage : scc_pkg

// File: scc_pol_detect.sv
// Polarity resolver: automatic or manual active sense of one sync input
`timescale 1ns/1ps
`default_nettype none
module scc_pol_detect
    import scc_pkg::*;
#(
    parameter int WIN = SCC_AUTO_WIN
) (
    input wire logic clk,          // Pixel domain clock
    input wire logic rst_n,        // Async reset, active low
    input wire logic sig_in,       // Raw sync input
    input wire logic [1:0] pol,    // Polarity field
    output logic active_high,      // Resolved sense, 1 = active high
    output logic sig_act           // Input, normalised to active high
);
    logic [$clog2(WIN)-1:0] win_q;
    logic [$clog2(WIN):0] high_q;
    logic auto_q;

    // Count high cycles per window; majority level is the inactive one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_q <= '0;
            high_q <= '0;
            auto_q <= 1'b0;
        end else begin
            win_q <= win_q + 1'b1;
            if (&win_q) begin
                auto_q <= (high_q < ($clog2(WIN)+1)'(WIN / 2));
                high_q <= '0;
            end else if (sig_in) begin
                high_q <= high_q + 1'b1;
            end
        end
    end

    assign active_high = pol[SCC_PF_MANUAL] ? pol[SCC_PF_LEVEL] : auto_q;
    assign sig_act = active_high ? sig_in : ~sig_in;

    // Manual mode follows the level bit with no delay
    manual_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
        pol[SCC_PF_MANUAL] |-> (active_high == pol[SCC_PF_LEVEL]))
        else $error("Manual polarity not applied");
endmodule : scc_pol_detect
`default_nettype wire

// File: scc_top.sv
// Top: sync polarity, clamp window, coast, clock select and regenerated line sync
`timescale 1ns/1ps
`default_nettype none
module scc_top
    import scc_pkg::*;
#(
    parameter int WIN = SCC_AUTO_WIN
) (
    input wire logic REF_CLK,                  // Pixel clock, 100 MHz
    input wire logic RSTN,                     // Async reset, active low
    input wire logic CHAN_SEL,                 // 0 selects set a, 1 set b
    input wire logic LINE_SYNC_IN_A,           // Line sync, set a
    input wire logic LINE_SYNC_IN_B,           // Line sync, set b
    input wire logic FRAME_SYNC_IN_A,          // Frame sync, set a
    input wire logic FRAME_SYNC_IN_B,          // Frame sync, set b
    input wire logic GREEN_SLICE_A,            // Sliced sync on green, set a
    input wire logic GREEN_SLICE_B,            // Sliced sync on green, set b
    input wire logic FILT_LINE_SYNC,           // Filtered line sync from filter
    input wire logic CLAMP_IN,                 // External clamp pin
    input wire logic COAST_IN,                 // Shared coast pin
    input wire logic POWER_DOWN_PIN,           // Power-down pin
    input wire scc_cfg_s CFG,                  // Configuration bits
    output logic [4:0] SLICE_THRESH,           // Slicer threshold code
    output logic SLICER_SYNC_OUT,              // Slicer output pin
    output logic PLL_REF_PULSE,                // Leading edge pulse to PLL
    output logic PLL_HOLD,                     // Coast hold to PLL
    output logic CLK_SEL_EXT,                  // Pixel clock from external pin
    output logic CLAMP_WINDOW,                 // Clamp active
    output logic FIELD_TICK,                   // Frame sync leading edge
    output logic POWER_DOWN,                   // Power down request
    output logic REGENERATED_LINE_SYNC_OUT,    // Regenerated line sync
    output logic [1:0] POL_STATUS              // Resolved line/frame sense
);
    typedef enum logic [1:0] {
        CL_IDLE = 2'b00,
        CL_DELAY = 2'b01,
        CL_ON = 2'b11
    } scc_clamp_e;

    logic line_raw, frame_raw, sog_raw;
    logic line_act, frame_act, clamp_act, coast_act;
    logic line_hi, frame_hi;
    logic line_d1_q, frame_d1_q;
    logic lead, trail, frame_lead;
    scc_clamp_e cl_q;
    logic [7:0] cl_cnt_q;
    logic [7:0] rg_cnt_q;
    logic rg_on_q;

    assign line_raw = CHAN_SEL ? LINE_SYNC_IN_B : LINE_SYNC_IN_A;
    assign frame_raw = CHAN_SEL ? FRAME_SYNC_IN_B : FRAME_SYNC_IN_A;
    assign sog_raw = CHAN_SEL ? GREEN_SLICE_B : GREEN_SLICE_A;

    scc_pol_detect #(.WIN(WIN)) u_line (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .sig_in(line_raw),
        .pol(CFG.line_pol),
        .active_high(line_hi),
        .sig_act(line_act)
    );
    scc_pol_detect #(.WIN(WIN)) u_frame (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .sig_in(frame_raw),
        .pol(CFG.frame_pol),
        .active_high(frame_hi),
        .sig_act(frame_act)
    );
    scc_pol_detect #(.WIN(WIN)) u_clamp (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .sig_in(CLAMP_IN),
        .pol(CFG.clamp_pol),
        .active_high(),
        .sig_act(clamp_act)
    );
    scc_pol_detect #(.WIN(WIN)) u_coast (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .sig_in(COAST_IN),
        .pol(CFG.coast_pol),
        .active_high(),
        .sig_act(coast_act)
    );

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            line_d1_q <= 1'b0;
            frame_d1_q <= 1'b0;
        end else begin
            line_d1_q <= line_act;
            frame_d1_q <= frame_act;
        end
    end

    // Active edge: rising of normalised sync, i.e. raw edge per sense
    assign lead = line_act & ~line_d1_q;
    assign trail = ~line_act & line_d1_q;
    assign frame_lead = frame_act & ~frame_d1_q;

    // Leading edge to PLL, masked while coasting
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PLL_REF_PULSE <= 1'b0;
            PLL_HOLD <= 1'b0;
        end else begin
            PLL_REF_PULSE <= lead & ~coast_act;
            PLL_HOLD <= coast_act;
        end
    end

    // Leading edge reaches PLL next clock
    sequence line_lead_s;
        lead && !coast_act;
    endsequence
    ref_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        line_lead_s |=> PLL_REF_PULSE)
        else $error("Leading edge not passed to PLL");

    sequence coast_on_s;
        coast_act;
    endsequence
    coast_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        coast_on_s |=> PLL_HOLD && !PLL_REF_PULSE)
        else $error("Coast did not hold the PLL");

    // Frame timing tick for field and coast logic
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            FIELD_TICK <= 1'b0;
        end else begin
            FIELD_TICK <= frame_lead;
        end
    end

    field_tick_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        frame_lead |=> FIELD_TICK)
        else $error("Frame edge lost");

    // Internal clamp: delay then width after trailing edge
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cl_q <= CL_IDLE;
            cl_cnt_q <= 8'h00;
        end else begin
            case (cl_q)
                CL_IDLE: begin
                    if (trail) begin
                        cl_cnt_q <= CFG.clamp_delay;
                        cl_q <= CL_DELAY;
                    end
                end
                CL_DELAY: begin
                    if (cl_cnt_q == 8'h00) begin
                        cl_cnt_q <= CFG.clamp_width;
                        cl_q <= CL_ON;
                    end else begin
                        cl_cnt_q <= cl_cnt_q - 8'h01;
                    end
                end
                CL_ON: begin
                    if (cl_cnt_q <= 8'h01) begin
                        cl_q <= CL_IDLE;
                    end else begin
                        cl_cnt_q <= cl_cnt_q - 8'h01;
                    end
                end
                default: begin
                    cl_q <= CL_IDLE;
                end
            endcase
        end
    end

    // Clamp count starts at trailing edge
    sequence trail_seen_s;
        trail && !CFG.clamp_ext && cl_q == CL_IDLE;
    endsequence
    sequence delay_loaded_s;
        cl_q == CL_DELAY && cl_cnt_q == $past(CFG.clamp_delay);
    endsequence
    clamp_start_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        trail_seen_s |=> delay_loaded_s)
        else $error("Clamp delay not started");

    clamp_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        cl_q == CL_ON && cl_cnt_q > 8'h01 |=> cl_q == CL_ON)
        else $error("Clamp window cut short");

    // External clamp honoured only when enabled
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            CLAMP_WINDOW <= 1'b0;
        end else if (CFG.clamp_ext) begin
            CLAMP_WINDOW <= clamp_act;
        end else begin
            CLAMP_WINDOW <= (cl_q == CL_ON) && (CFG.clamp_width != 8'h00);
        end
    end

    sequence ext_off_idle_s;
        !CFG.clamp_ext && cl_q != CL_ON;
    endsequence
    clamp_gate_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ext_off_idle_s |=> !CLAMP_WINDOW)
        else $error("Clamp pin honoured while disabled");

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            CLK_SEL_EXT <= 1'b0;
        end else begin
            CLK_SEL_EXT <= CFG.ext_clk;
        end
    end

    clk_sel_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        CFG.ext_clk |=> CLK_SEL_EXT)
        else $error("External clock not selected");

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            POWER_DOWN <= 1'b0;
        end else begin
            POWER_DOWN <= CFG.pd_sel & (POWER_DOWN_PIN == CFG.pd_pol);
        end
    end

    pd_sel_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !CFG.pd_sel |=> !POWER_DOWN)
        else $error("Power-down without pin select");

    // Threshold code, every code in range
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            SLICE_THRESH <= SCC_SLICE_DEF_CODE;
        end else begin
            SLICE_THRESH <= CFG.slice_code;
        end
    end

    // Regenerated pulse from leading edge, width in pixel clocks
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rg_cnt_q <= 8'h00;
            rg_on_q <= 1'b0;
        end else if (lead && CFG.regen_width != 8'h00) begin
            rg_cnt_q <= CFG.regen_width - 8'h01;
            rg_on_q <= 1'b1;
        end else if (rg_cnt_q != 8'h00) begin
            rg_cnt_q <= rg_cnt_q - 8'h01;
        end else begin
            rg_on_q <= 1'b0;
        end
    end

    // Registered on the pixel clock that also drives data out
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REGENERATED_LINE_SYNC_OUT <= 1'b0;
        end else begin
            REGENERATED_LINE_SYNC_OUT <= rg_on_q ~^ CFG.regen_pol;
        end
    end

    // Pulse starts one clock after launch and shows on the pin one clock later
    sequence regen_launch_s;
        lead && CFG.regen_width != 8'h00;
    endsequence
    sequence regen_shown_s;
        rg_on_q ##1 (REGENERATED_LINE_SYNC_OUT == CFG.regen_pol);
    endsequence
    regen_start_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        regen_launch_s |=> regen_shown_s)
        else $error("Regenerated pulse missing");

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            SLICER_SYNC_OUT <= 1'b0;
        end else begin
            case (scc_src_e'(CFG.slicer_sel))
                SCC_SRC_SOG: SLICER_SYNC_OUT <= sog_raw;
                SCC_SRC_LINE: SLICER_SYNC_OUT <= line_raw;
                SCC_SRC_REGEN: SLICER_SYNC_OUT <= rg_on_q ~^ CFG.regen_pol;
                SCC_SRC_FILT: SLICER_SYNC_OUT <= FILT_LINE_SYNC;
                default: SLICER_SYNC_OUT <= sog_raw;
            endcase
        end
    end

    // Regenerated source matches its own pin
    slicer_regen_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $past(CFG.slicer_sel) == SCC_SRC_REGEN |->
        SLICER_SYNC_OUT == REGENERATED_LINE_SYNC_OUT)
        else $error("Slicer regenerated source misaligned");

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            POL_STATUS <= 2'h0;
        end else begin
            POL_STATUS <= {frame_hi, line_hi};
        end
    end

endmodule : scc_top
`default_nettype wire

// File: scc_src_model.sv
// Video source model: emits one line sync pulse of chosen sense on request
`timescale 1ns/1ps
`default_nettype none
module scc_src_model (
    input wire logic clk,     // Pixel clock
    input wire logic go,      // Start one line pulse
    input wire logic act_hi,  // Sense of the emitted pulse
    output logic line_sync    // Line sync towards the device
);
    logic [3:0] cnt_q = 4'h0;
    // Fixed eight-cycle pulse, idle level is the inactive sense
    always_ff @(posedge clk) begin
        if (go) begin
            cnt_q <= 4'h8;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    assign line_sync = (cnt_q != 4'h0) ? act_hi : ~act_hi;
endmodule // scc_src_model
`default_nettype wire

// File: tb_scc_top.sv
// Testbench for the sync, clamp and coast control top
`timescale 1ns/1ps
`default_nettype none
module tb_scc_top;
    import scc_pkg::*;
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic chan = 1'b0, frame_a = 1'b0, frame_b = 1'b0, green_a = 1'b0, green_b = 1'b0;
    logic filt = 1'b0, clamp = 1'b0, coast = 1'b0, pdn = 1'b0, go = 1'b0, act_hi = 1'b0;
    logic line_a, line_b = 1'b1;
    scc_cfg_s cfg = '0;
    logic [4:0] thresh;
    logic slicer, ref_p, hold, ext, clampw, tick, pd, regen;
    logic [1:0] pol_st;
    logic exp_bit;
    int failures = 0, n_checks = 0, n_ref, n_clamp, n_regen, n_tick;
    always #5 REF_CLK = ~REF_CLK;
    scc_src_model src (.clk(REF_CLK), .go(go), .act_hi(act_hi), .line_sync(line_a));
    scc_top #(.WIN(16)) dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .CHAN_SEL(chan),
        .LINE_SYNC_IN_A(line_a), .LINE_SYNC_IN_B(line_b), .FRAME_SYNC_IN_A(frame_a),
        .FRAME_SYNC_IN_B(frame_b), .GREEN_SLICE_A(green_a), .GREEN_SLICE_B(green_b),
        .FILT_LINE_SYNC(filt), .CLAMP_IN(clamp), .COAST_IN(coast), .POWER_DOWN_PIN(pdn),
        .CFG(cfg), .SLICE_THRESH(thresh), .SLICER_SYNC_OUT(slicer), .PLL_REF_PULSE(ref_p),
        .PLL_HOLD(hold), .CLK_SEL_EXT(ext), .CLAMP_WINDOW(clampw), .FIELD_TICK(tick),
        .POWER_DOWN(pd), .REGENERATED_LINE_SYNC_OUT(regen), .POL_STATUS(pol_st));
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Let n edges pass, then sample clear of the edge
    task tick_n(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Count activity of the timed outputs over one line
    task run_line(input logic hi);
        @(posedge REF_CLK);
        go <= 1'b1;
        @(posedge REF_CLK);
        go <= 1'b0;
        n_ref = 0;
        n_clamp = 0;
        n_regen = 0;
        repeat (40) begin
            tick_n(1);
            n_ref += int'(ref_p === 1'b1);
            n_clamp += int'(clampw === 1'b1);
            n_regen += int'(regen === 1'b1);
        end
    endtask
    initial begin
        #200us;
        failures++;
        test_done();
    end
    initial begin
        cfg.coast_pol = SCC_COAST_POL_RST;
        cfg.slice_code = SCC_SLICE_DEF_CODE;
        cfg.line_pol = 2'h2;
        repeat (6) @(posedge REF_CLK);
        RSTN <= 1'b1;
        tick_n(4);
        chk("clk_sel_rst", 8'(ext), 8'h0);
        chk("thresh_def", 8'(thresh), 8'(SCC_SLICE_DEF_CODE));
        @(posedge REF_CLK);
        cfg.ext_clk <= 1'b1;
        cfg.slice_code <= 5'h1f;
        tick_n(4);
        chk("clk_sel_ext", 8'(ext), 8'h1);
        chk("thresh_max", 8'(thresh), 8'h1f);
        // Slicer sources with both levels and both channel sets; regenerated source at its idle level only
        for (int v = 0; v < 4; v++) begin
            @(posedge REF_CLK);
            chan <= v[1];
            green_a <= v[0] ^ v[1];
            green_b <= v[0];
            act_hi <= v[0];
            line_b <= ~v[0];
            filt <= v[0];
            for (int s = 0; s < 4; s++) begin
                @(posedge REF_CLK);
                cfg.slicer_sel <= 2'(s);
                tick_n(4);
                // Regenerated source idles high while its sense is active low
                exp_bit = (s == 1) ? ~v[0] : ((s == 2) ? 1'b1 : v[0]);
                chk("slicer_out", 8'(slicer), 8'(exp_bit));
            end
        end
        @(posedge REF_CLK);
        chan <= 1'b0;
        act_hi <= 1'b0;
        // Power-down select and pin sense
        for (int v = 0; v < 8; v++) begin
            @(posedge REF_CLK);
            cfg.pd_sel <= v[2];
            cfg.pd_pol <= v[1];
            pdn <= v[0];
            tick_n(4);
            chk("power_down", 8'(pd), 8'(v[2] & (v[1] ~^ v[0])));
        end
        @(posedge REF_CLK);
        pdn <= 1'b0;
        cfg.pd_pol <= 1'b1;
        // Manual coast sense, both levels
        for (int v = 0; v < 4; v++) begin
            @(posedge REF_CLK);
            cfg.coast_pol <= {1'b1, v[1]};
            coast <= v[0];
            tick_n(4);
            exp_bit = v[1] ~^ v[0];
            chk("pll_hold", 8'(hold), 8'(exp_bit));
        end
        @(posedge REF_CLK);
        coast <= 1'b0;
        cfg.coast_pol <= 2'h3;
        // External clamp honoured only when enabled
        for (int v = 0; v < 6; v++) begin
            @(posedge REF_CLK);
            cfg.clamp_ext <= (v < 4);
            cfg.clamp_pol <= {1'b1, v[1]};
            clamp <= v[0];
            tick_n(4);
            exp_bit = (v < 4) & (v[1] ~^ v[0]);
            chk("clamp_ext", 8'(clampw), 8'(exp_bit));
        end
        @(posedge REF_CLK);
        clamp <= 1'b0;
        cfg.clamp_ext <= 1'b0;
        cfg.clamp_delay <= 8'h4;
        cfg.clamp_width <= 8'h6;
        cfg.regen_width <= 8'h5;
        cfg.regen_pol <= 1'b1;
        // Both senses of line sync: edge use, clamp count, regenerated pulse
        for (int v = 0; v < 2; v++) begin
            @(posedge REF_CLK);
            cfg.line_pol <= {1'b1, v[0]};
            act_hi <= v[0];
            tick_n(8);
            run_line(v[0]);
            chk("pll_ref_seen", 8'(n_ref), 8'h1);
            chk("clamp_count", 8'(n_clamp), 8'h6);
            chk("regen_count", 8'(n_regen), 8'h5);
        end
        // Frame sync leading edge and resolved senses
        @(posedge REF_CLK);
        cfg.frame_pol <= 2'h3;
        tick_n(4);
        chk("pol_status_hi", 8'(pol_st), 8'h3);
        @(posedge REF_CLK);
        frame_a <= 1'b1;
        n_tick = 0;
        repeat (10) begin
            tick_n(1);
            n_tick += int'(tick === 1'b1);
        end
        chk("field_tick", 8'(n_tick), 8'h1);
        @(posedge REF_CLK);
        cfg.line_pol <= 2'h2;
        cfg.frame_pol <= 2'h2;
        tick_n(4);
        chk("pol_status_lo", 8'(pol_st), 8'h0);
        test_done();
    end
endmodule // tb_scc_top
`default_nettype wire
